// file: dmarb_cfg.svh
// Register offsets, field positions, reset values and timing counts of the DMA arbiter block.
`ifndef DMARB_CFG_SVH
`define DMARB_CFG_SVH
// =============================================================
// Register map (byte addresses)
`define DMARB_OFS_BUS_MODE 12'h000
`define DMARB_OFS_IRQ_STATUS 12'h028
`define DMARB_OFS_OP_MODE 12'h030
`define DMARB_OFS_IRQ_MASK 12'h038
`define DMARB_OFS_ENGINE 12'h040
// =============================================================
// Field positions
`define DMARB_BM_SWRST 0
`define DMARB_BM_RXPRIO 1
`define DMARB_OM_THR_LO 14
`define DMARB_OM_THR_HI 15
`define DMARB_EN_RXRUN 0
`define DMARB_EN_TXRUN 1
// Implemented status bits: 0,1,2,3,5,6,7,8,9,10,11,13.
`define DMARB_IRQ_IMPL 32'h0000_2FEF
// =============================================================
// Reset values
`define DMARB_RST_BUS_MODE 32'h0000_0000
`define DMARB_RST_OP_MODE 32'h0000_0000
`define DMARB_RST_IRQ_MASK 32'h0000_0000
// =============================================================
// Reset sequence timing
`define DMARB_RST_SEQ_NS 1000
`define DMARB_CLK_NS 40
`define DMARB_RST_SEQ_CYC ((`DMARB_RST_SEQ_NS) / (`DMARB_CLK_NS))
`endif

// file: dmarb_host.sv
// Host processor model: APB master that reaches the block registers.
`timescale 1ns/1ps
module dmarb_host (
	input wire logic clk_sys,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output dmarb_pkg::dmarb_apb_req_t req
);
	import dmarb_pkg::*;
	// ==============================================================
	// Bus transfers
	// The bus is idle from time zero so no transfer is seen before reset.
	initial req = '0;
	// One transfer; the request stands until pready is sampled high.
	// Released data and address lines are inverted so stale values never look valid.
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge clk_sys);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= wr;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge clk_sys);
		req.penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		req.paddr <= ~a;
		req.pwdata <= ~d;
	endtask
	// The host stays off the bus after any reset before it speaks again.
	task automatic settle;
		repeat (50) @(posedge clk_sys);
	endtask
endmodule

// file: dmarb_pkg.sv
// Types shared by the DMA arbiter block.
package dmarb_pkg;
	// =============================================================
	// Reset sequencer states, Gray coded along the path.
	typedef enum logic [1:0] {
		DMARB_RS_RESET = 2'b00,
		DMARB_RS_RUN = 2'b01
	} dmarb_rst_st_t;
	// Grant owner.
	typedef enum logic [1:0] {
		DMARB_G_NONE = 2'b00,
		DMARB_G_RX = 2'b01,
		DMARB_G_TX = 2'b11
	} dmarb_grant_t;
	// DMA request inputs grouped together.
	typedef struct packed {
		logic tx_req;
		logic rx_req;
		logic tx_on_wire;
		logic rx_free_ok;
		logic tx_free_ok;
		logic rx_pkt_end;
		logic tx_pkt_end;
		logic burst_done;
	} dmarb_req_t;
	// APB slave signals toward the block.
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} dmarb_apb_req_t;
endpackage

// file: dmarb_tb.sv
// Self-checking testbench of the reset, DMA arbiter and interrupt block.
`timescale 1ns/1ps
`include "dmarb_cfg.svh"
module testbench;
	import dmarb_pkg::*;
	localparam logic [11:0] A_BM = `DMARB_OFS_BUS_MODE;
	localparam logic [11:0] A_ST = `DMARB_OFS_IRQ_STATUS;
	localparam logic [11:0] A_OM = `DMARB_OFS_OP_MODE;
	localparam logic [11:0] A_MK = `DMARB_OFS_IRQ_MASK;
	localparam logic [11:0] A_EN = `DMARB_OFS_ENGINE;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic hw_rst_n = 1'b1;
	logic cfg_we = 1'b0;
	logic [31:0] cfg_wdata = 32'h0000_0000;
	logic [31:0] irq_events = 32'h0000_0000;
	dmarb_req_t dma_in = '0;
	dmarb_apb_req_t apb_req;
	logic [31:0] prdata, cfg_rdata, rdv;
	logic pready, pslverr, rx_running, tx_running, engine_reset, desc_wb_en, rst_busy, irq_out;
	logic rerr;
	logic [1:0] dma_grant, op_thresh;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	int lows;
	// ==============================================================
	// Instances
	dmarb_host host (.clk_sys, .prdata, .pready, .pslverr, .req(apb_req));
	// A short reset sequence keeps the run brief.
	dmarb_top #(.RST_CYC(2)) dut (.clk_sys, .rst, .hw_rst_n, .apb_req, .prdata, .pready,
		.pslverr, .dma_in, .irq_events, .cfg_wdata, .cfg_we, .cfg_rdata, .dma_grant,
		.op_thresh, .rx_running, .tx_running, .engine_reset, .desc_wb_en, .rst_busy,
		.irq_out);
	// The clock never stops, resets included.
	always #20 clk_sys = ~clk_sys;
	// A hang is cut short well above the expected run length.
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			error_cnt++;
			final_report();
		end
	end
	// ==============================================================
	// Helpers
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rdv, rerr);
	endtask
	task automatic rd(input logic [11:0] a);
		host.xfer(1'b0, a, 32'h0000_0000, rdv, rerr);
	endtask
	// Drops requests and closes the burst; the grant must then fall.
	task automatic rel;
		@(posedge clk_sys);
		{dma_in.tx_req, dma_in.rx_req, dma_in.burst_done} <= 3'b001;
		@(posedge clk_sys);
		dma_in.burst_done <= 1'b0;
		@(negedge clk_sys);
		chk("grant_rel", dma_grant, 2'b00);
	endtask
	// Vector v is tx_req, rx_req, tx_on_wire, rx_free_ok, tx_free_ok.
	task automatic arb(input logic [4:0] v, input logic [1:0] exp);
		@(posedge clk_sys);
		{dma_in.tx_req, dma_in.rx_req, dma_in.tx_on_wire, dma_in.rx_free_ok,
			dma_in.tx_free_ok} <= v;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk("grant", dma_grant, exp);
		rel();
	endtask
	// Both request; a packet end on the winner must hand the next burst over.
	task automatic owe(input logic [2:0] v, input logic [1:0] g1, input logic [1:0] g2);
		arb_hold(v);
		chk("owe_first", dma_grant, g1);
		@(posedge clk_sys);
		dma_in.burst_done <= 1'b1;
		dma_in.rx_pkt_end <= (g1 == DMARB_G_RX);
		dma_in.tx_pkt_end <= (g1 == DMARB_G_TX);
		@(posedge clk_sys);
		{dma_in.burst_done, dma_in.rx_pkt_end, dma_in.tx_pkt_end} <= 3'b000;
		@(negedge clk_sys);
		chk("owe_next", dma_grant, g2);
		rel();
	endtask
	task automatic arb_hold(input logic [2:0] v);
		@(posedge clk_sys);
		{dma_in.tx_req, dma_in.rx_req} <= 2'b11;
		{dma_in.tx_on_wire, dma_in.rx_free_ok, dma_in.tx_free_ok} <= v;
		@(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	// One event pulse, then time for status and the line to follow.
	task automatic ev(input logic [31:0] m);
		@(posedge clk_sys);
		irq_events <= m;
		@(posedge clk_sys);
		irq_events <= 32'h0000_0000;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	// Clearing write, counting cycles with the line low afterwards.
	task automatic clr(input logic [31:0] m);
		wr(A_ST, m);
		lows = 0;
		repeat (5) begin
			@(negedge clk_sys);
			if (irq_out !== 1'b1) lows++;
		end
	endtask
	// ==============================================================
	// Scenarios
	task automatic t_reset;
		@(negedge clk_sys);
		chk("busy_in_rst", rst_busy, 1'b1);
		chk("eng_rst", engine_reset, 1'b1);
		chk("wb_in_rst", desc_wb_en, 1'b0);
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		host.settle();
		@(negedge clk_sys);
		chk("busy_done", rst_busy, 1'b0);
		chk("wb_on", desc_wb_en, 1'b1);
		chk("rx_stop", rx_running, 1'b0);
		chk("tx_stop", tx_running, 1'b0);
		chk("irq_idle", irq_out, 1'b0);
		$display("test reset done");
	endtask
	task automatic t_soft;
		rd(12'h0FC);
		chk("unmapped_err", rerr, 1'b1);
		chk("unmapped_rd", rdv, 32'h0000_0000);
		@(posedge clk_sys);
		{cfg_we, cfg_wdata} <= {1'b1, 32'h1234_5678};
		@(posedge clk_sys);
		cfg_we <= 1'b0;
		wr(A_OM, 32'h0000_8000);
		wr(A_MK, 32'h0000_0041);
		@(negedge clk_sys);
		chk("thresh", op_thresh, 2'b10);
		wr(A_BM, 32'h0000_0001);
		wr(A_BM, 32'h0000_0001);
		@(negedge clk_sys);
		chk("soft_busy", rst_busy, 1'b1);
		host.settle();
		@(negedge clk_sys);
		chk("cfg_kept", cfg_rdata, 32'h1234_5678);
		chk("thresh_rst", op_thresh, 2'b00);
		rd(A_MK);
		chk("mask_rst", rdv, 32'h0000_0000);
		@(posedge clk_sys);
		hw_rst_n <= 1'b0;
		@(posedge clk_sys);
		hw_rst_n <= 1'b1;
		@(negedge clk_sys);
		chk("hw_busy", rst_busy, 1'b1);
		host.settle();
		@(negedge clk_sys);
		chk("cfg_hw_rst", cfg_rdata, 32'h0000_0000);
		chk("hw_done", rst_busy, 1'b0);
		$display("test soft reset done");
	endtask
	task automatic t_arb;
		arb(5'b01000, DMARB_G_NONE);
		wr(A_EN, 32'h0000_0003);
		@(negedge clk_sys);
		chk("run", {rx_running, tx_running}, 2'b11);
		arb(5'b11000, DMARB_G_TX);
		wr(A_BM, 32'h0000_0002);
		arb(5'b01000, DMARB_G_RX);
		arb(5'b01100, DMARB_G_RX);
		arb(5'b10000, DMARB_G_TX);
		arb(5'b10100, DMARB_G_TX);
		arb(5'b11000, DMARB_G_RX);
		arb(5'b11100, DMARB_G_TX);
		arb(5'b11101, DMARB_G_TX);
		arb(5'b11110, DMARB_G_TX);
		arb(5'b11111, DMARB_G_RX);
		owe(3'b000, DMARB_G_RX, DMARB_G_TX);
		owe(3'b100, DMARB_G_TX, DMARB_G_RX);
		$display("test arbiter done");
	endtask
	task automatic t_irq;
		wr(A_MK, `DMARB_IRQ_IMPL);
		ev(32'h0000_0041);
		chk("irq_one", irq_out, 1'b1);
		ev(32'h0000_0040);
		wr(A_ST, 32'h0000_0000);
		rd(A_ST);
		chk("st_keep", rdv, 32'h0000_0041);
		ev(32'h0000_0080);
		clr(32'h0000_0041);
		chk("irq_drop", lows, 1);
		chk("irq_back", irq_out, 1'b1);
		rd(A_ST);
		chk("st_left", rdv, 32'h0000_0080);
		clr(32'h0000_0080);
		chk("irq_clear", irq_out, 1'b0);
		ev(32'h0000_0800);
		chk("irq_new", irq_out, 1'b1);
		wr(A_MK, 32'h0000_0000);
		clr(32'h0000_0800);
		ev(32'h0000_2000);
		chk("irq_masked", irq_out, 1'b0);
		wr(A_MK, `DMARB_IRQ_IMPL);
		repeat (3) @(negedge clk_sys);
		chk("irq_unmask", irq_out, 1'b1);
		clr(32'h0000_2000);
		for (int i = 0; i < 32; i++) begin
			ev(32'h0000_0001 << i);
			rd(A_ST);
			chk("st_bit", rdv, (32'h0000_0001 << i) & `DMARB_IRQ_IMPL);
			wr(A_ST, 32'h0000_0001 << i);
			rd(A_ST);
			chk("st_w1c", rdv, 32'h0000_0000);
		end
		$display("test interrupts done");
	endtask
	// ==============================================================
	// Main sequence and verdict
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		t_reset();
		t_soft();
		t_arb();
		t_irq();
		final_report();
	end
endmodule

// file: dmarb_top.sv
// Reset sequencer, DMA channel arbiter and interrupt status logic of the LAN controller.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "dmarb_cfg.svh"

module dmarb_top #(
	parameter int RST_CYC = `DMARB_RST_SEQ_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic hw_rst_n,
	input wire dmarb_pkg::dmarb_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire dmarb_pkg::dmarb_req_t dma_in,
	input wire logic [31:0] irq_events,
	input wire logic [31:0] cfg_wdata,
	input wire logic cfg_we,
	output logic [31:0] cfg_rdata,
	output logic [1:0] dma_grant,
	output logic [1:0] op_thresh,
	output logic rx_running,
	output logic tx_running,
	output logic engine_reset,
	output logic desc_wb_en,
	output logic rst_busy,
	output logic irq_out
);
	import dmarb_pkg::*;

	// =============================================================
	// Reset sequencer
	localparam logic [5:0] RST_CNT = 6'(RST_CYC);
	dmarb_rst_st_t rst_st_ff, nxt_rst_st;
	logic [5:0] rst_cnt_ff, nxt_rst_cnt;
	logic hw_rst_ff, nxt_hw_rst;
	logic sw_rst_wr;
	logic soft_clear;

	// Pin or software bit starts the sequence; each new command reloads the count.
	always_comb begin
		nxt_rst_st = rst_st_ff;
		nxt_rst_cnt = rst_cnt_ff;
		nxt_hw_rst = ~hw_rst_n;
		if (~hw_rst_n || sw_rst_wr) begin
			nxt_rst_st = DMARB_RS_RESET;
			nxt_rst_cnt = RST_CNT;
		end else if (rst_st_ff == DMARB_RS_RESET) begin
			case (rst_cnt_ff)
				6'h00: nxt_rst_st = DMARB_RS_RUN;
				default: nxt_rst_cnt = rst_cnt_ff - 6'h01;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rst_st_ff <= DMARB_RS_RESET;
			rst_cnt_ff <= RST_CNT;
			hw_rst_ff <= 1'b1;
		end else begin
			rst_st_ff <= nxt_rst_st;
			rst_cnt_ff <= nxt_rst_cnt;
			hw_rst_ff <= nxt_hw_rst;
		end
	end

	// Any reset phase clears engines and host-visible registers.
	assign soft_clear = (rst_st_ff == DMARB_RS_RESET) || ~hw_rst_n || sw_rst_wr;
	assign rst_busy = (rst_st_ff == DMARB_RS_RESET);
	assign engine_reset = soft_clear;
	// Descriptor write-back is blocked so ownership may stay with the device.
	assign desc_wb_en = ~soft_clear;

	// =============================================================
	// APB slave; zero wait states, pslverr on unmapped addresses.
	logic wr_en, rd_en;
	logic [31:0] bus_mode_ff, nxt_bus_mode;
	logic [31:0] op_mode_ff, nxt_op_mode;
	logic [31:0] irq_mask_ff, nxt_irq_mask;
	logic [31:0] irq_status_ff, nxt_irq_status;
	logic [1:0] run_ff, nxt_run;
	logic [31:0] cfg_ff, nxt_cfg;
	logic [31:0] prdata_ff, nxt_prdata;
	logic mapped;
	logic clr_wr;

	assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd_en = apb_req.psel && apb_req.penable && ~apb_req.pwrite;
	assign sw_rst_wr = wr_en && (apb_req.paddr == `DMARB_OFS_BUS_MODE)
		&& apb_req.pwdata[`DMARB_BM_SWRST];
	assign pready = 1'b1;
	assign clr_wr = wr_en && (apb_req.paddr == `DMARB_OFS_IRQ_STATUS)
		&& ((apb_req.pwdata & `DMARB_IRQ_IMPL) != 32'h0000_0000);

	always_comb begin
		case (apb_req.paddr)
			`DMARB_OFS_BUS_MODE, `DMARB_OFS_IRQ_STATUS, `DMARB_OFS_OP_MODE,
			`DMARB_OFS_IRQ_MASK, `DMARB_OFS_ENGINE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr = apb_req.psel && apb_req.penable && ~mapped;

	// Register writes, status set-over-clear, and read data capture.
	always_comb begin
		nxt_bus_mode = bus_mode_ff;
		nxt_op_mode = op_mode_ff;
		nxt_irq_mask = irq_mask_ff;
		nxt_run = run_ff;
		nxt_cfg = cfg_ff;
		nxt_prdata = 32'h0000_0000;
		// Hardware set wins over a same-cycle clear so no event is lost.
		nxt_irq_status = irq_status_ff;
		if (wr_en && apb_req.paddr == `DMARB_OFS_IRQ_STATUS) begin
			nxt_irq_status = irq_status_ff & ~apb_req.pwdata;
		end
		nxt_irq_status = (nxt_irq_status | irq_events) & `DMARB_IRQ_IMPL;
		if (wr_en) begin
			case (apb_req.paddr)
				`DMARB_OFS_BUS_MODE: nxt_bus_mode = apb_req.pwdata & 32'h0000_0002;
				`DMARB_OFS_OP_MODE: nxt_op_mode = apb_req.pwdata;
				`DMARB_OFS_IRQ_MASK: nxt_irq_mask = apb_req.pwdata & `DMARB_IRQ_IMPL;
				`DMARB_OFS_ENGINE: nxt_run = apb_req.pwdata[1:0];
				default: nxt_run = run_ff;
			endcase
		end
		if (rd_en) begin
			case (apb_req.paddr)
				`DMARB_OFS_BUS_MODE: nxt_prdata = bus_mode_ff;
				`DMARB_OFS_IRQ_STATUS: nxt_prdata = irq_status_ff;
				`DMARB_OFS_OP_MODE: nxt_prdata = op_mode_ff;
				`DMARB_OFS_IRQ_MASK: nxt_prdata = irq_mask_ff;
				`DMARB_OFS_ENGINE: nxt_prdata = {30'h0000_0000, run_ff};
				default: nxt_prdata = 32'h0000_0000;
			endcase
		end
		if (soft_clear) begin
			nxt_bus_mode = `DMARB_RST_BUS_MODE;
			nxt_op_mode = `DMARB_RST_OP_MODE;
			nxt_irq_mask = `DMARB_RST_IRQ_MASK;
			nxt_irq_status = 32'h0000_0000;
			nxt_run = 2'b00;
		end
		// Configuration space only follows the pin reset, not the software bit.
		if (cfg_we) begin
			nxt_cfg = cfg_wdata;
		end
		if (~hw_rst_n) begin
			nxt_cfg = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bus_mode_ff <= `DMARB_RST_BUS_MODE;
			op_mode_ff <= `DMARB_RST_OP_MODE;
			irq_mask_ff <= `DMARB_RST_IRQ_MASK;
			irq_status_ff <= 32'h0000_0000;
			run_ff <= 2'b00;
			cfg_ff <= 32'h0000_0000;
			prdata_ff <= 32'h0000_0000;
		end else begin
			bus_mode_ff <= nxt_bus_mode;
			op_mode_ff <= nxt_op_mode;
			irq_mask_ff <= nxt_irq_mask;
			irq_status_ff <= nxt_irq_status;
			run_ff <= nxt_run;
			cfg_ff <= nxt_cfg;
			prdata_ff <= nxt_prdata;
		end
	end

	// Read data is driven straight from the registers during the access; prdata_ff holds it for one cycle afterwards.
	assign prdata = rd_en ? nxt_prdata : prdata_ff;
	assign cfg_rdata = cfg_ff;
	assign op_thresh = op_mode_ff[`DMARB_OM_THR_HI:`DMARB_OM_THR_LO];
	assign rx_running = run_ff[`DMARB_EN_RXRUN];
	assign tx_running = run_ff[`DMARB_EN_TXRUN];

	// =============================================================
	// DMA arbiter; grant holds until burst_done or a reset phase.
	dmarb_grant_t grant_ff, nxt_grant;
	logic tx_owed_ff, nxt_tx_owed;
	logic rx_owed_ff, nxt_rx_owed;
	logic txr, rxr;
	logic tx_due, rx_due;

	// Requests only count while the engines run and no reset is pending.
	assign txr = dma_in.tx_req && tx_running && ~soft_clear;
	assign rxr = dma_in.rx_req && rx_running && ~soft_clear;
	// A packet end beside burst_done already owes the very next burst to the other side.
	assign tx_due = tx_owed_ff || dma_in.rx_pkt_end;
	assign rx_due = rx_owed_ff || dma_in.tx_pkt_end;

	always_comb begin
		nxt_grant = grant_ff;
		nxt_tx_owed = tx_owed_ff;
		nxt_rx_owed = rx_owed_ff;
		// A packet end owes the other side one burst window.
		if (dma_in.rx_pkt_end) nxt_tx_owed = 1'b1;
		if (dma_in.tx_pkt_end) nxt_rx_owed = 1'b1;
		if (grant_ff == DMARB_G_NONE || dma_in.burst_done) begin
			nxt_grant = DMARB_G_NONE;
			if (txr && rxr) begin
				if (tx_due) begin
					nxt_grant = DMARB_G_TX;
				end else if (rx_due) begin
					nxt_grant = DMARB_G_RX;
				end else if (!bus_mode_ff[`DMARB_BM_RXPRIO]) begin
					nxt_grant = DMARB_G_TX;
				end else if (!dma_in.tx_on_wire) begin
					nxt_grant = DMARB_G_RX;
				end else if (dma_in.rx_free_ok && dma_in.tx_free_ok) begin
					nxt_grant = DMARB_G_RX;
				end else begin
					nxt_grant = DMARB_G_TX;
				end
			end else if (rxr) begin
				nxt_grant = DMARB_G_RX;
			end else if (txr) begin
				nxt_grant = DMARB_G_TX;
			end
			if (nxt_grant == DMARB_G_TX) nxt_tx_owed = 1'b0;
			if (nxt_grant == DMARB_G_RX) nxt_rx_owed = 1'b0;
		end
		if (soft_clear) begin
			nxt_grant = DMARB_G_NONE;
			nxt_tx_owed = 1'b0;
			nxt_rx_owed = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			grant_ff <= DMARB_G_NONE;
			tx_owed_ff <= 1'b0;
			rx_owed_ff <= 1'b0;
		end else begin
			grant_ff <= nxt_grant;
			tx_owed_ff <= nxt_tx_owed;
			rx_owed_ff <= nxt_rx_owed;
		end
	end

	assign dma_grant = grant_ff;

	// =============================================================
	// Interrupt line: masked OR, dropped one cycle after a clearing write.
	logic irq_ff, nxt_irq;
	logic clr_seen_ff;
	logic pend;

	assign pend = |(irq_status_ff & irq_mask_ff);
	// A clearing write makes a one-cycle gap so an edge-sensitive host sees a new interrupt.
	always_comb begin
		nxt_irq = pend && ~clr_seen_ff && ~soft_clear;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_ff <= 1'b0;
			clr_seen_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
			clr_seen_ff <= clr_wr;
		end
	end

	assign irq_out = irq_ff;

	// =============================================================
	// Assertions.
	sequence s_clear_write;
		clr_wr;
	endsequence
	sequence s_gap_then_line;
		##1 1'b1 ##1 !irq_out;
	endsequence
	sequence s_cmd_released;
		(!hw_rst_n || sw_rst_wr) ##1 (hw_rst_n && !sw_rst_wr);
	endsequence

	a_line_gap_after_clear: assert property (
		@(posedge clk_sys) disable iff (rst) s_clear_write |-> s_gap_then_line)
		else $error("interrupt line not dropped after clearing write");
	a_status_clears_on_one: assert property (
		@(posedge clk_sys) disable iff (rst)
		(wr_en && apb_req.paddr == `DMARB_OFS_IRQ_STATUS && apb_req.pwdata[6]
		&& !irq_events[6] && !soft_clear) |=> !irq_status_ff[6])
		else $error("status bit six not cleared by write of one");
	a_status_sticky: assert property (
		@(posedge clk_sys) disable iff (rst)
		(irq_status_ff[0] && !clr_wr && !soft_clear) |=> irq_status_ff[0])
		else $error("status bit lost without a clearing write");
	a_masked_line_off: assert property (
		@(posedge clk_sys) disable iff (rst) (irq_mask_ff == 32'h0000_0000) |=> !irq_out)
		else $error("interrupt raised with all causes masked");
	a_line_follows_pend: assert property (
		@(posedge clk_sys) disable iff (rst) (pend && !clr_seen_ff && !soft_clear) |=> irq_out)
		else $error("interrupt line not raised for pending cause");
	a_reset_finishes: assert property (
		@(posedge clk_sys) disable iff (rst)
		s_cmd_released |-> ##[0:50] !rst_busy)
		else $error("reset sequence longer than fifty cycles");
	a_soft_keeps_cfg: assert property (
		@(posedge clk_sys) disable iff (rst)
		(sw_rst_wr && hw_rst_n && !cfg_we) |=> $stable(cfg_ff))
		else $error("software reset changed configuration register");
	a_reset_stops_engines: assert property (
		@(posedge clk_sys) disable iff (rst)
		soft_clear |=> (!rx_running && !tx_running && dma_grant == DMARB_G_NONE))
		else $error("engines not stopped by reset");
	a_idle_wire_rx: assert property (
		@(posedge clk_sys) disable iff (rst)
		(grant_ff == DMARB_G_NONE && txr && rxr && !tx_due && !rx_due
		&& bus_mode_ff[`DMARB_BM_RXPRIO] && !dma_in.tx_on_wire) |=> dma_grant == DMARB_G_RX)
		else $error("receive not chosen on idle wire");
	a_busy_wire_tx: assert property (
		@(posedge clk_sys) disable iff (rst)
		(grant_ff == DMARB_G_NONE && txr && rxr && !tx_due && !rx_due
		&& dma_in.tx_on_wire && !dma_in.rx_free_ok) |=> dma_grant == DMARB_G_TX)
		else $error("transmit not chosen with receive FIFO short");
	a_tx_window: assert property (
		@(posedge clk_sys) disable iff (rst)
		((grant_ff == DMARB_G_NONE || dma_in.burst_done) && txr && tx_due)
		|=> dma_grant == DMARB_G_TX)
		else $error("transmit window after receive packet missed");
	a_rx_window: assert property (
		@(posedge clk_sys) disable iff (rst)
		((grant_ff == DMARB_G_NONE || dma_in.burst_done) && txr && rxr && rx_due && !tx_due)
		|=> dma_grant == DMARB_G_RX)
		else $error("receive window after transmit packet missed");
	a_cmd_starts_reset: assert property (
		@(posedge clk_sys) disable iff (rst) (!hw_rst_n || sw_rst_wr) |=> rst_busy)
		else $error("reset command did not start the sequence");
	a_no_writeback: assert property (
		@(posedge clk_sys) disable iff (rst) rst_busy |-> !desc_wb_en)
		else $error("descriptor write-back enabled during reset");
	a_pin_clears_cfg: assert property (
		@(posedge clk_sys) disable iff (rst) hw_rst_ff |-> (cfg_ff == 32'h0000_0000))
		else $error("pin reset left configuration register set");
	a_line_no_repulse: assert property (
		@(posedge clk_sys) disable iff (rst)
		(irq_out && !$past(wr_en) && !clr_seen_ff && !soft_clear) |=> irq_out)
		else $error("interrupt line pulsed again without a clearing write");
	a_line_quiet: assert property (
		@(posedge clk_sys) disable iff (rst) !pend |=> !irq_out)
		else $error("interrupt raised with no pending cause");
endmodule
